// *** verilog/amc_regs.svh ***
// Register map, field positions, reset values and timing counts of the audio clocking block
`ifndef AMC_REGS_SVH
`define AMC_REGS_SVH
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
// Byte offsets
`define AMC_CTRL_OFS 8'h00
`define AMC_STATUS_OFS 8'h04
`define AMC_PERIOD_OFS 8'h08
`define AMC_TXDATA_OFS 8'h0C
`define AMC_MICDATA_OFS 8'h10
// Control fields
`define AMC_C_ENABLE 0
`define AMC_C_MASTER 1
`define AMC_C_DRATE 2
`define AMC_C_MUSIC 3
`define AMC_C_OSR64 4
`define AMC_C_SLOT 5
`define AMC_C_RATE_LSB 8
`define AMC_C_MDIV_LSB 12
// Status fields
`define AMC_S_LOCKED 0
`define AMC_S_RATE_ERR 1
`define AMC_S_RATIO_ERR 2
`define AMC_S_LOCK_TMO 3
`define AMC_S_LOCK_LOST 4
`define AMC_S_SDO_DRIVE 5
// Reset values
`define AMC_CTRL_RST 32'h0000_0000
`define AMC_TXDATA_RST 16'h0000
// Timing
`define AMC_CLK_HZ 100000000
`define AMC_CLK_MHZ 100
`define AMC_LOCK_MAX_MS 7
`define AMC_LOCK_CYC (`AMC_LOCK_MAX_MS * (`AMC_CLK_HZ / 1000))
`define AMC_JITTER_NS 100
`define AMC_JITTER_CYC ((`AMC_JITTER_NS * `AMC_CLK_MHZ) / 1000)
`define AMC_GLITCH_NS 50
`define AMC_GLITCH_CYC ((`AMC_GLITCH_NS * `AMC_CLK_MHZ) / 1000)
`define AMC_LOCK_FRAMES 4
`define AMC_PER_8K (`AMC_CLK_HZ / 8000)
`define AMC_PER_48K_LO (`AMC_CLK_HZ / 48000)
`define AMC_PER_48K_HI ((`AMC_CLK_HZ + 47999) / 48000)
`define AMC_PER_96K (`AMC_CLK_HZ / 96000)
`define AMC_RATIO_VOICE 256
`define AMC_RATIO_OSR64 208
`define AMC_RATIO_DRATE 128
`define AMC_TX_BITS 16
`endif

// *** verilog/amc_pkg.sv ***
// Types shared by the audio clocking block
package amc_pkg;
  // Frame lock tracker states
  typedef enum logic [1:0] {
    LK_OFF,
    LK_ACQUIRE,
    LK_LOCKED
  } amc_lock_type;
endpackage : amc_pkg

// *** verilog/amc_mic_div.sv ***
// Divider that makes the microphone clock and its edge pulses
`timescale 1ns/1ps
module amc_mic_div (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [2:0] mic_clock_divider_select,
  output logic mic_clock_out,
  output logic mic_rise,
  output logic mic_fall
);
  logic [3:0] cnt;
  logic [3:0] div;
  logic [3:0] next_cnt;
  logic next_out;

  // Select code to divisor; unsupported codes fall back to eight
  always_comb begin
    unique case (mic_clock_divider_select)
      3'h0: div = 4'h2;
      3'h1: div = 4'h3;
      3'h2: div = 4'h4;
      3'h3: div = 4'h5;
      3'h4: div = 4'h6;
      3'h5: div = 4'h8;
      default: div = 4'h8;
    endcase
  end

  // Count wraps at the divisor; odd divisors run low one cycle longer
  always_comb begin
    next_cnt = (cnt >= div - 4'h1) ? 4'h0 : cnt + 4'h1;
    next_out = next_cnt < (div >> 1);
  end

  // Clock and one-cycle edge pulses, all registered
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt <= 4'h0;
      mic_clock_out <= 1'b0;
      mic_rise <= 1'b0;
      mic_fall <= 1'b0;
    end else begin
      cnt <= next_cnt;
      mic_clock_out <= next_out;
      mic_rise <= next_out & ~mic_clock_out;
      mic_fall <= ~next_out & mic_clock_out;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // Period of the clock equals the divisor
  div_bound_a: assert property (cnt < div || $changed(mic_clock_divider_select))
    else $error("mic divider count past divisor");
  div_two_a: assert property (mic_clock_divider_select == 3'h0 && $stable(mic_clock_divider_select)
    && mic_rise |=> mic_fall)
    else $error("divide by two not alternating");
endmodule : amc_mic_div

// *** verilog/amc_clocking.sv ***
// Frame clock checking and generation, lock tracking, mic clock, slot output, control-line filter
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "amc_regs.svh"
module amc_clocking #(
  parameter int unsigned LOCK_TIMEOUT_CYC = `AMC_LOCK_CYC
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic frame_clock_in,
  output logic frame_clock_out,
  output logic frame_clock_oe_n,
  input wire logic bit_clock_in,
  output logic serial_data_out,
  output logic serial_data_oe_n,
  output logic mic_clock_out,
  input wire logic mic_data_in,
  input wire logic ctl_scl_in,
  input wire logic ctl_sda_in,
  output logic ctl_scl_filtered,
  output logic ctl_sda_filtered,
  output logic pll_locked
);
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // Least period in clocks for the selected filter set
  function automatic logic [15:0] min_ratio(input logic drate, input logic music, input logic osr64);
    if (drate) begin
      return 16'(`AMC_RATIO_DRATE);
    end else if (music && osr64) begin
      return 16'(`AMC_RATIO_OSR64);
    end
    return 16'(`AMC_RATIO_VOICE);
  endfunction : min_ratio

  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : abs_diff

  // Nominal frame rate per code; unlisted codes run the 48 kHz default
  function automatic logic [31:0] rate_of(input logic [3:0] code);
    unique case (code)
      4'h8: return 32'd8000;
      4'h9: return 32'd11025;
      4'hA: return 32'd12000;
      4'hB: return 32'd16000;
      4'hC: return 32'd22050;
      4'hD: return 32'd24000;
      4'hE: return 32'd32000;
      4'hF: return 32'd44100;
      default: return 32'd48000;
    endcase
  endfunction : rate_of

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: frame, bit clock, mic data, scl, sda; reset to idle levels so no false edge follows
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [2:0] pin_last;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= 5'h1A;
      pin_sync <= 5'h1A;
      pin_last <= 3'h2;
    end else begin
      pin_meta <= {ctl_sda_in, ctl_scl_in, mic_data_in, bit_clock_in, frame_clock_in};
      pin_sync <= pin_meta;
      pin_last <= pin_sync[2:0];
    end
  end
  logic frame_rise;
  logic bit_fall;
  assign frame_rise = pin_sync[0] & ~pin_last[0];
  assign bit_fall = ~pin_sync[1] & pin_last[1];

  ////////////////////////////////////////////////////////////////////////////
  // Register bus: one wait cycle on every access
  logic ack;
  logic [31:0] ctrl;
  logic [15:0] tx_word;
  logic wr_go;
  logic rd_go;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_go = avs_write & ack;
  assign rd_go = avs_read & ~ack;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  // Control fields
  logic enable, master, drate, music, osr64, slot_mode;
  logic [3:0] sample_rate_code;
  logic [2:0] mic_clock_divider_select;
  assign enable = ctrl[`AMC_C_ENABLE];
  assign master = ctrl[`AMC_C_MASTER];
  assign drate = ctrl[`AMC_C_DRATE];
  assign music = ctrl[`AMC_C_MUSIC];
  assign osr64 = ctrl[`AMC_C_OSR64];
  assign slot_mode = ctrl[`AMC_C_SLOT];
  assign sample_rate_code = ctrl[`AMC_C_RATE_LSB +: 4];
  assign mic_clock_divider_select = ctrl[`AMC_C_MDIV_LSB +: 3];

  // Writable registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl <= `AMC_CTRL_RST;
      tx_word <= `AMC_TXDATA_RST;
    end else if (wr_go) begin
      if (avs_address == `AMC_CTRL_OFS) begin
        ctrl <= be_merge(ctrl, avs_writedata, avs_byteenable) & 32'h0000_7F3F;
      end
      if (avs_address == `AMC_TXDATA_OFS) begin
        tx_word <= 16'(be_merge({16'h0000, tx_word}, avs_writedata, avs_byteenable));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame period measurement on the synchronised frame pin
  logic [15:0] per_cnt;
  logic [15:0] period;
  logic [15:0] prev_period;
  logic per_done;
  logic per_stall;
  assign per_stall = per_cnt == 16'hFFFF;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      per_cnt <= 16'h0000;
      period <= 16'h0000;
      prev_period <= 16'h0000;
      per_done <= 1'b0;
    end else begin
      per_done <= frame_rise & enable;
      if (frame_rise) begin
        per_cnt <= 16'h0001;
        period <= per_cnt;
        prev_period <= period;
      end else if (!per_stall) begin
        per_cnt <= per_cnt + 16'h0001;
      end
    end
  end

  // Rate and ratio checks per finished period
  logic rate_bad;
  logic ratio_bad;
  always_comb begin
    if (drate) begin
      rate_bad = period < 16'(`AMC_PER_96K) || period > 16'(`AMC_PER_48K_HI);
    end else begin
      rate_bad = period < 16'(`AMC_PER_48K_LO) || period > 16'(`AMC_PER_8K);
    end
    ratio_bad = period < min_ratio(drate, music, osr64);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock tracker: consistent periods lead to lock; a timeout only flags and restarts, acquisition goes on
  amc_pkg::amc_lock_type lk_state;
  logic [2:0] good_cnt;
  logic [19:0] lk_timer;
  logic jit_ok;
  logic lock_tmo_ev;
  logic lock_lost_ev;
  assign jit_ok = abs_diff(period, prev_period) <= 16'(`AMC_JITTER_CYC);
  assign lock_tmo_ev = lk_state == amc_pkg::LK_ACQUIRE && lk_timer == 20'(LOCK_TIMEOUT_CYC - 1);
  assign lock_lost_ev = lk_state == amc_pkg::LK_LOCKED && ((per_done && !jit_ok) || per_stall);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lk_state <= amc_pkg::LK_OFF;
      good_cnt <= 3'h0;
      lk_timer <= 20'h0_0000;
    end else if (!enable) begin
      lk_state <= amc_pkg::LK_OFF;
    end else begin
      unique case (lk_state)
        amc_pkg::LK_OFF: begin
          lk_state <= amc_pkg::LK_ACQUIRE;
          good_cnt <= 3'h0;
          lk_timer <= 20'h0_0000;
        end
        amc_pkg::LK_ACQUIRE: begin
          // Timer restarts after each timeout so acquisition keeps trying
          lk_timer <= lock_tmo_ev ? 20'h0_0000 : lk_timer + 20'h0_0001;
          if (per_done) begin
            good_cnt <= jit_ok ? good_cnt + 3'h1 : 3'h0;
            if (jit_ok && good_cnt == 3'(`AMC_LOCK_FRAMES - 1)) begin
              lk_state <= amc_pkg::LK_LOCKED;
            end
          end
        end
        amc_pkg::LK_LOCKED: begin
          // Periods within the jitter window keep lock
          if (lock_lost_ev) begin
            lk_state <= amc_pkg::LK_ACQUIRE;
            good_cnt <= 3'h0;
            lk_timer <= 20'h0_0000;
          end
        end
      endcase
    end
  end
  assign pll_locked = lk_state == amc_pkg::LK_LOCKED;

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status; a set in the clearing cycle wins
  logic [3:0] sticky;
  logic [3:0] sticky_set;
  assign sticky_set = {lock_lost_ev, lock_tmo_ev, per_done & ratio_bad, per_done & rate_bad};
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sticky <= 4'h0;
    end else begin
      if (wr_go && avs_address == `AMC_STATUS_OFS) begin
        sticky <= (sticky & ~avs_writedata[`AMC_S_LOCK_LOST:`AMC_S_RATE_ERR]) | sticky_set;
      end else begin
        sticky <= sticky | sticky_set;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master frame generator: Bresenham step of twice the rate against the clock
  // keeps the average exact, at the cost of one clock of edge wander
  logic [31:0] fg_acc;
  logic [32:0] fg_sum;
  logic fg_wrap;
  assign fg_sum = {1'b0, fg_acc} + {rate_of(sample_rate_code), 1'b0};
  assign fg_wrap = fg_sum >= 33'(`AMC_CLK_HZ);
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fg_acc <= 32'h0000_0000;
      frame_clock_out <= 1'b0;
      frame_clock_oe_n <= 1'b1;
    end else if (enable && master) begin
      frame_clock_oe_n <= 1'b0;
      fg_acc <= fg_wrap ? 32'(fg_sum - 33'(`AMC_CLK_HZ)) : fg_sum[31:0];
      if (fg_wrap) begin
        frame_clock_out <= ~frame_clock_out;
      end
    end else begin
      fg_acc <= 32'h0000_0000;
      frame_clock_out <= 1'b0;
      frame_clock_oe_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial data output: MSB on the first bit clock fall after a frame start
  logic tx_pend;
  logic [15:0] tx_shift;
  logic [3:0] tx_left;
  logic tx_drive;
  logic lsb_end;
  assign lsb_end = bit_fall && !tx_pend && tx_drive && tx_left == 4'h0;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_pend <= 1'b0;
      tx_shift <= 16'h0000;
      tx_left <= 4'h0;
      tx_drive <= 1'b0;
    end else if (!enable) begin
      tx_pend <= 1'b0;
      tx_drive <= 1'b0;
    end else begin
      if (frame_rise) begin
        tx_pend <= 1'b1;
      end else if (bit_fall && tx_pend) begin
        tx_pend <= 1'b0;
      end
      if (bit_fall && tx_pend) begin
        tx_shift <= tx_word;
        tx_left <= 4'(`AMC_TX_BITS - 1);
        tx_drive <= 1'b1;
      end else if (bit_fall && tx_left != 4'h0) begin
        tx_shift <= {tx_shift[14:0], 1'b0};
        tx_left <= tx_left - 4'h1;
      end else if (lsb_end && slot_mode) begin
        tx_drive <= 1'b0;
      end
    end
  end
  assign serial_data_out = tx_shift[15];
  assign serial_data_oe_n = ~tx_drive;

  ////////////////////////////////////////////////////////////////////////////
  // Mic clock and dual-edge capture: left on rise, right on fall
  logic mic_rise;
  logic mic_fall;
  logic [15:0] mic_left;
  logic [15:0] mic_right;
  amc_mic_div u_mic_div (
    .clock(clock),
    .resetn(resetn),
    .mic_clock_divider_select(mic_clock_divider_select),
    .mic_clock_out(mic_clock_out),
    .mic_rise(mic_rise),
    .mic_fall(mic_fall)
  );
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mic_left <= 16'h0000;
      mic_right <= 16'h0000;
    end else begin
      if (mic_rise) begin
        mic_left <= {mic_left[14:0], pin_sync[2]};
      end
      if (mic_fall) begin
        mic_right <= {mic_right[14:0], pin_sync[2]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control line spike filter: a level must persist past the spike width
  logic [1:0] ctl_filt;
  logic [2:0] gl_cnt [2];
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctl_filt <= 2'b11;
      gl_cnt[0] <= 3'h0;
      gl_cnt[1] <= 3'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (pin_sync[3+i] == ctl_filt[i]) begin
          gl_cnt[i] <= 3'h0;
        end else if (gl_cnt[i] == 3'(`AMC_GLITCH_CYC)) begin
          ctl_filt[i] <= pin_sync[3+i];
          gl_cnt[i] <= 3'h0;
        end else begin
          gl_cnt[i] <= gl_cnt[i] + 3'h1;
        end
      end
    end
  end
  assign ctl_scl_filtered = ctl_filt[0];
  assign ctl_sda_filtered = ctl_filt[1];

  ////////////////////////////////////////////////////////////////////////////
  // Read data, loaded in the wait cycle; unmapped offsets read zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_go) begin
      unique case (avs_address)
        `AMC_CTRL_OFS: avs_readdata <= ctrl;
        `AMC_STATUS_OFS: avs_readdata <= {26'h000_0000, tx_drive, sticky, pll_locked};
        `AMC_PERIOD_OFS: avs_readdata <= {16'h0000, period};
        `AMC_TXDATA_OFS: avs_readdata <= {16'h0000, tx_word};
        `AMC_MICDATA_OFS: avs_readdata <= {mic_right, mic_left};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held more than one cycle");
  rate_flag_a: assert property (per_done && !drate && period > 16'(`AMC_PER_8K)
    |=> sticky[0])
    else $error("slow frame not flagged");
  ratio_flag_a: assert property (per_done && drate && period < 16'(`AMC_RATIO_DRATE)
    |=> sticky[1])
    else $error("low clock ratio not flagged");
  lock_time_a: assert property (lk_state == amc_pkg::LK_ACQUIRE && enable
    && lk_timer == 20'(LOCK_TIMEOUT_CYC - 1) |=> sticky[2])
    else $error("lock timeout not flagged");
  jitter_hold_a: assert property (pll_locked && enable && per_done && jit_ok && !per_stall
    |=> pll_locked)
    else $error("lock dropped within jitter bound");
  gen_exact_a: assert property (enable && master && $stable(sample_rate_code) && fg_wrap
    |=> $changed(frame_clock_out) && !frame_clock_oe_n)
    else $error("frame generator missed a step");
  mic_sample_a: assert property (mic_fall |=> mic_right[0] == $past(pin_sync[2]))
    else $error("falling edge mic bit not taken");
  slot_release_a: assert property (enable && slot_mode && lsb_end && !frame_rise
    |=> serial_data_oe_n ##1 serial_data_oe_n)
    else $error("data output not released after LSB");
  spike_a: assert property ($changed(ctl_scl_filtered)
    |-> $past(pin_sync[3], 1) == $past(pin_sync[3], 6))
    else $error("short spike passed filter");

  lock_seen_c: cover property (pll_locked && per_done);
  release_seen_c: cover property (lsb_end && slot_mode);
  rate_err_c: cover property ($rose(sticky[0]));
  mic_both_c: cover property (mic_rise ##[1:8] mic_fall);
endmodule : amc_clocking

// *** tb/amc_far_model.sv ***
// Far-side model: host frame and bit clocks, slot receiver and a stereo PDM microphone pair
`timescale 1ns/1ps
module amc_far_model (
  input wire logic clock,
  input wire logic mic_clock_out,
  input wire logic serial_data_out,
  input wire logic serial_data_oe_n,
  output logic frame_drive,
  output logic bit_clock_in,
  output logic mic_data_in
);
  logic mic_l = 1'b0;
  logic mic_r = 1'b0;
  logic [15:0] cap = 16'h0000;
  logic drv16 = 1'b1;
  logic rel = 1'b0;
  logic sd_line;

  // No pull on the data line: a released output reads as the inverse of its last value
  assign sd_line = serial_data_oe_n ? ~serial_data_out : serial_data_out;

  // Bit clock idles high and only runs inside a slot
  initial begin
    frame_drive = 1'b0;
    bit_clock_in = 1'b1;
    mic_data_in = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Each channel's bit is set up half a mic period ahead of the edge that takes it
  always @(posedge clock) begin
    mic_data_in <= mic_clock_out ? mic_r : mic_l;
  end

  // Jitter-free frames; a period out of range is only ever asked for by the bench
  task frames(input int half, input int n);
    repeat (n) begin
      repeat (half) @(posedge clock);
      frame_drive <= 1'b1;
      repeat (half) @(posedge clock);
      frame_drive <= 1'b0;
    end
  endtask : frames

  // One slot: frame rise, 17 bit clocks, data taken on rises, release seen after fall 17
  task slot(input int half);
    frame_drive <= 1'b1;
    for (int k = 1; k <= 17; k++) begin
      repeat (half) @(posedge clock);
      bit_clock_in <= 1'b0;
      repeat (half) @(posedge clock);
      bit_clock_in <= 1'b1;
      if (k <= 16) cap <= {cap[14:0], sd_line};
      if (k == 16) drv16 <= serial_data_oe_n;
    end
    rel <= serial_data_oe_n;
    frame_drive <= 1'b0;
  endtask : slot
endmodule : amc_far_model

// *** tb/audio_clocking_and_mic_clock_test.sv ***
// Testbench of the audio clocking block
`timescale 1ns/1ps
module audio_clocking_and_mic_clock_test;
  typedef struct packed {
    logic [7:0] a;
    logic [3:0] be;
    logic [31:0] d;
    logic [31:0] e;
  } amc_row_type;
  logic clock, resetn, avs_read, avs_write, avs_waitrequest, frame_clock_out, frame_clock_oe_n;
  logic bit_clock_in, serial_data_out, serial_data_oe_n, mic_clock_out, mic_data_in, pll_locked;
  logic ctl_scl_in, ctl_sda_in, ctl_scl_filtered, ctl_sda_filtered, frame_drive, frame_pin;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  int errors, check_count, g;
  int div [6] = '{2, 3, 4, 5, 6, 8};
  logic [31:0] ectl [3] = '{32'h0000_0019, 32'h0000_0001, 32'h0000_0005};
  logic [31:0] eexp [3] = '{32'h0000_0002, 32'h0000_0006, 32'h0000_0002};
  amc_row_type rows [6] = '{'{8'h00, 4'hF, 32'hFFFF_FFFF, 32'h0000_7F3F},
    '{8'h00, 4'h2, 32'h0000_0000, 32'h0000_003F}, '{8'h00, 4'hF, 32'h0000_0000, 32'h0000_0000},
    '{8'h0C, 4'hF, 32'hFFFF_ABCD, 32'h0000_ABCD}, '{8'h0C, 4'h2, 32'h0000_12FF, 32'h0000_12CD},
    '{8'h14, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000}};

  // Frame pin: the block's driver wins while its enable is low
  assign frame_pin = frame_clock_oe_n ? frame_drive : frame_clock_out;

  amc_clocking #(.LOCK_TIMEOUT_CYC(2000)) dut_u (.clock(clock), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .frame_clock_in(frame_pin), .frame_clock_out(frame_clock_out),
    .frame_clock_oe_n(frame_clock_oe_n), .bit_clock_in(bit_clock_in), .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n), .mic_clock_out(mic_clock_out), .mic_data_in(mic_data_in),
    .ctl_scl_in(ctl_scl_in), .ctl_sda_in(ctl_sda_in), .ctl_scl_filtered(ctl_scl_filtered),
    .ctl_sda_filtered(ctl_sda_filtered), .pll_locked(pll_locked));

  amc_far_model far_u (.clock(clock), .mic_clock_out(mic_clock_out), .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n), .frame_drive(frame_drive), .bit_clock_in(bit_clock_in),
    .mic_data_in(mic_data_in));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task stop_test();
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One bus transfer: the request stands until the rising edge at which waitrequest is seen low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
           output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 40) begin
      errors++;
      stop_test();
    end
  endtask : bus

  // Clocks between two rises of the frame output (sel=1) or the mic clock (sel=0)
  task gap(input logic sel, output int c);
    int n, r;
    logic p, s;
    n = 0;
    r = 0;
    c = 0;
    p = 1'b1;
    while (r < 2 && n < 20000) begin
      @(negedge clock);
      s = sel ? frame_clock_out : mic_clock_out;
      c++;
      if (s === 1'b1 && p === 1'b0) begin
        r++;
        if (r == 1) c = 0;
      end
      p = s;
      n++;
    end
    if (n >= 20000) begin
      errors++;
      stop_test();
    end
  endtask : gap

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    {avs_read, avs_write, avs_address, avs_byteenable, avs_writedata} = '0;
    ctl_scl_in = 1'b1;
    ctl_sda_in = 1'b1;
    errors = 0;
    check_count = 0;
    repeat (4) @(negedge clock);
    chk({26'd0, frame_clock_oe_n, serial_data_oe_n, ctl_scl_filtered, ctl_sda_filtered, pll_locked,
         mic_clock_out}, 32'h0000_003C);
    chk(avs_readdata, 32'h0000_0000);
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    // Register table: write each row, read it back
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d, rows[i].be, q);
      bus(1'b0, rows[i].a, 32'h0000_0000, 4'hF, q);
      chk(q, rows[i].e);
    end
    // Mic clock divisor for every supported code
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 8'h00, {17'd0, i[2:0], 12'd0}, 4'hF, q);
      repeat (20) @(posedge clock);
      gap(1'b0, g);
      chk(32'(g), 32'(div[i]));
    end
    // Both mic edges take data: left on rises, right on falls
    far_u.mic_l = 1'b1;
    repeat (200) @(posedge clock);
    bus(1'b0, 8'h10, 32'h0000_0000, 4'hF, q);
    chk(q, 32'h0000_FFFF);
    far_u.mic_l = 1'b0;
    far_u.mic_r = 1'b1;
    repeat (200) @(posedge clock);
    bus(1'b0, 8'h10, 32'h0000_0000, 4'hF, q);
    chk(q, 32'hFFFF_0000);
    // Too-fast frames: rate flag always, ratio flag only where the mode minimum is missed
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 8'h00, ectl[i], 4'hF, q);
      bus(1'b1, 8'h04, 32'h0000_001E, 4'hF, q);
      far_u.frames(115, 3);
      bus(1'b0, 8'h04, 32'h0000_0000, 4'hF, q);
      chk(q & 32'h0000_0006, eexp[i]);
    end
    // Master at 16 kHz, looped back to the frame input
    bus(1'b1, 8'h00, 32'h0000_0B03, 4'hF, q);
    gap(1'b1, g);
    chk(32'(g), 32'd6250);
    chk({31'd0, frame_clock_oe_n}, 32'h0000_0000);
    for (int n = 0; n < 60000 && pll_locked !== 1'b1; n++) @(negedge clock);
    chk({31'd0, pll_locked}, 32'h0000_0001);
    if (pll_locked !== 1'b1) stop_test();
    bus(1'b1, 8'h04, 32'h0000_001E, 4'hF, q);
    gap(1'b1, g);
    bus(1'b0, 8'h04, 32'h0000_0000, 4'hF, q);
    chk(q & 32'h0000_0006, 32'h0000_0000);
    bus(1'b0, 8'h08, 32'h0000_0000, 4'hF, q);
    chk(q & 32'h0000_FFFF, 32'h0000_186A);
    // Slot mode: 16 bits MSB first, then the output is let go
    bus(1'b1, 8'h00, 32'h0000_0021, 4'hF, q);
    bus(1'b1, 8'h0C, 32'h0000_A5C3, 4'hF, q);
    repeat (20) @(posedge clock);
    far_u.slot(8);
    @(negedge clock);
    chk({15'd0, far_u.drv16, far_u.cap}, 32'h0000_A5C3);
    chk({31'd0, far_u.rel}, 32'h0000_0001);
    // A 50 ns spike must not pass; a longer low must
    @(posedge clock);
    ctl_scl_in <= 1'b0;
    ctl_sda_in <= 1'b0;
    repeat (5) @(posedge clock);
    ctl_scl_in <= 1'b1;
    ctl_sda_in <= 1'b1;
    repeat (12) begin
      @(negedge clock);
      chk({30'd0, ctl_scl_filtered, ctl_sda_filtered}, 32'h0000_0003);
    end
    @(posedge clock);
    ctl_scl_in <= 1'b0;
    ctl_sda_in <= 1'b0;
    // Low phase as short as a 400 kHz serial clock allows
    repeat (130) @(posedge clock);
    @(negedge clock);
    chk({30'd0, ctl_scl_filtered, ctl_sda_filtered}, 32'h0000_0000);
    // Mid-run reset returns outputs and registers to their idle values
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk({26'd0, frame_clock_oe_n, serial_data_oe_n, ctl_scl_filtered, ctl_sda_filtered, pll_locked,
         mic_clock_out}, 32'h0000_003C);
    @(posedge clock);
    resetn <= 1'b1;
    bus(1'b0, 8'h00, 32'h0000_0000, 4'hF, q);
    chk(q, 32'h0000_0000);
    stop_test();
  end
endmodule : audio_clocking_and_mic_clock_test
